// ===== shared/icp_pkg.sv
// shared constants, encodings and carriers of the instruction cycle pipeline
package icp_pkg;
  // ****************************************
  // widths and vectors
  // ****************************************
  localparam int PC_W = 13;
  localparam int IW = 16;
  localparam int DW = 8;
  localparam logic [PC_W-1:0] RESET_VEC = 13'h0000;
  localparam int STACK_LVLS = 8;
  localparam int PAGE_LSB = 8;

  // ****************************************
  // oscillator sources and their step divisors
  // ****************************************
  localparam logic [1:0] SRC_HS_XTAL = 2'h0;
  localparam logic [1:0] SRC_LS_XTAL = 2'h1;
  localparam logic [1:0] SRC_HS_IRC = 2'h2;
  localparam logic [1:0] SRC_LS_IRC = 2'h3;
  localparam logic [5:0] DIV_HS_XTAL = 6'h01;
  localparam logic [5:0] DIV_LS_XTAL = 6'h20;
  localparam logic [5:0] DIV_HS_IRC = 6'h02;
  localparam logic [5:0] DIV_LS_IRC = 6'h28;

  // ****************************************
  // instruction word layout
  // ****************************************
  localparam int OP_MSB = 15;
  localparam int OP_LSB = 13;
  localparam int FN_MSB = 11;
  localparam int FN_LSB = 8;
  localparam int DIR_BIT = 8;
  localparam logic [2:0] OP_MISC = 3'h0;
  localparam logic [2:0] OP_ALU_LIT = 3'h1;
  localparam logic [2:0] OP_ALU_MEM = 3'h2;
  localparam logic [2:0] OP_MOV = 3'h3;
  localparam logic [2:0] OP_SKIP = 3'h4;
  localparam logic [2:0] OP_EXT = 3'h5;
  localparam logic [2:0] OP_JMP = 3'h6;
  localparam logic [2:0] OP_CALL = 3'h7;
  localparam logic [3:0] MISC_NOP = 4'h0;
  localparam logic [3:0] MISC_RET = 4'h1;

  // alu functions
  localparam logic [3:0] FN_ADD = 4'h0;
  localparam logic [3:0] FN_SUB = 4'h1;
  localparam logic [3:0] FN_AND = 4'h2;
  localparam logic [3:0] FN_OR = 4'h3;
  localparam logic [3:0] FN_XOR = 4'h4;
  localparam logic [3:0] FN_LOAD = 4'h5;
  localparam logic [3:0] FN_INC = 4'h6;
  localparam logic [3:0] FN_DEC = 4'h7;
  localparam logic [3:0] FN_RR = 4'h8;
  localparam logic [3:0] FN_RL = 4'h9;

  // ****************************************
  // special registers in data memory
  // ****************************************
  localparam logic [7:0] SFR_IND = 8'h00;
  localparam logic [7:0] SFR_MP = 8'h01;
  localparam logic [7:0] SFR_ACC = 8'h02;
  localparam logic [7:0] SFR_PC_LOW = 8'h03;
  localparam logic [7:0] SFR_STATUS = 8'h04;
  localparam int ST_Z = 0;
  localparam int ST_C = 1;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {PH_T1, PH_T2, PH_T3, PH_T4} icp_phase_t;

  typedef struct packed {
    logic rd;
    logic [PC_W-1:0] addr;
  } icp_pm_req_t;

  typedef struct packed {
    logic alu_lit;
    logic alu_mem;
    logic ext;
    logic acc_only;
    logic mov_wr;
    logic mov_rd;
    logic skip;
    logic skip_nz;
    logic jmp;
    logic call;
    logic ret;
    logic [3:0] fn;
    logic [7:0] arg;
    logic [PC_W-1:0] target;
  } icp_dec_t;
endpackage

// ===== verilog/icp_phase_gen.sv
// oscillator source select and four-phase splitter
`timescale 1ns/10ps
module icp_phase_gen import icp_pkg::*; (
  input wire logic core_clk, // system clock
  input wire logic sys_rst, // synchronous reset, high
  input wire logic [1:0] clk_src_sel, // source select pin
  output icp_phase_t phase_q, // current phase
  output logic step_q // last core cycle of phase
);
  logic [1:0] sel_meta_q;
  logic [1:0] sel_q;
  logic [5:0] cnt_q;
  logic [5:0] div;

  // ****************************************
  // source select
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sel_meta_q <= SRC_HS_XTAL;
      sel_q <= SRC_HS_XTAL;
    end else begin
      sel_meta_q <= clk_src_sel;
      sel_q <= sel_meta_q;
    end
  end

  // each source is a step rate derived from core_clk
  always_comb begin
    unique case (sel_q)
      SRC_HS_XTAL: div = DIV_HS_XTAL;
      SRC_LS_XTAL: div = DIV_LS_XTAL;
      SRC_HS_IRC: div = DIV_HS_IRC;
      SRC_LS_IRC: div = DIV_LS_IRC;
    endcase
  end

  // ****************************************
  // divider and phase ring
  // ****************************************
  // >= so a switch to a faster source never overruns the counter
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cnt_q <= 6'h00;
      step_q <= 1'b0;
    end else if (cnt_q >= div - 6'h01) begin
      cnt_q <= 6'h00;
      step_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 6'h01;
      step_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      phase_q <= PH_T1;
    end else if (step_q) begin
      unique case (phase_q)
        PH_T1: phase_q <= PH_T2;
        PH_T2: phase_q <= PH_T3;
        PH_T3: phase_q <= PH_T4;
        PH_T4: phase_q <= PH_T1;
      endcase
    end
  end
endmodule

// ===== verilog/icp_core.sv
// instruction fetch and execute sequencing core
`timescale 1ns/10ps
module icp_core import icp_pkg::*; #(
  parameter int DMEM_DEPTH = 256
) (
  input wire logic core_clk, // 20 MHz system clock
  input wire logic sys_rst, // synchronous reset, high
  input wire logic [1:0] clk_src_sel, // oscillator source pin
  output icp_pm_req_t pm_req, // program memory request
  input wire logic [IW-1:0] pm_data, // word, valid at end of cycle
  output icp_phase_t phase, // current phase
  output logic instr_retire, // pulse per completed instruction
  output logic dummy_cycle, // cycle executes nothing
  output logic [DW-1:0] acc_out // accumulator
);
  icp_phase_t phase_q;
  logic step_q;
  icp_pm_req_t pm_req_q;
  logic [PC_W-1:0] pc_q;
  logic [IW-1:0] exec_ir_q;
  logic [PC_W-1:0] exec_pc_q;
  logic exec_valid_q;
  logic fetch_pend_q;
  logic held_q;
  logic [IW-1:0] fetch_q;
  logic ext_wait_q;
  logic dummy_q;
  logic retire_q;
  logic [DW-1:0] acc_q;
  logic [DW-1:0] mp_q;
  logic [1:0] status_q;
  logic [DW-1:0] opnd_q;
  logic [DW-1:0] dmem [DMEM_DEPTH];
  logic [PC_W-1:0] stack_q [STACK_LVLS];
  logic [2:0] sp_q;

  icp_phase_gen u_phase (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .clk_src_sel(clk_src_sel),
    .phase_q(phase_q),
    .step_q(step_q)
  );

  // ****************************************
  // decode and alu
  // ****************************************
  function automatic icp_dec_t decode(input logic [IW-1:0] ir);
    icp_dec_t d;
    logic [2:0] op;
    d = '0;
    op = ir[OP_MSB:OP_LSB];
    d.fn = ir[FN_MSB:FN_LSB];
    d.arg = ir[7:0];
    d.target = ir[PC_W-1:0];
    d.alu_lit = (op == OP_ALU_LIT);
    d.alu_mem = (op == OP_ALU_MEM) || (op == OP_EXT);
    d.ext = (op == OP_EXT);
    d.ret = (op == OP_MISC) && (d.fn == MISC_RET);
    d.acc_only = (op == OP_MISC) && (d.fn != MISC_NOP) && !d.ret;
    d.mov_wr = (op == OP_MOV) && !ir[DIR_BIT];
    d.mov_rd = (op == OP_MOV) && ir[DIR_BIT];
    d.skip = (op == OP_SKIP);
    d.skip_nz = ir[DIR_BIT];
    d.jmp = (op == OP_JMP);
    d.call = (op == OP_CALL);
    return d;
  endfunction

  // one 8-bit unit for the alu, memory and accumulator-only ops; moves bypass it; returns {carry, result}
  function automatic logic [DW:0] alu(input logic [3:0] fn, input logic [DW-1:0] a,
                                      input logic [DW-1:0] b, input logic cin);
    logic [DW:0] r;
    r = {cin, a};
    unique case (fn)
      FN_ADD: r = {1'b0, a} + {1'b0, b};
      FN_SUB: r = {1'b0, a} - {1'b0, b};
      FN_AND: r = {cin, a & b};
      FN_OR: r = {cin, a | b};
      FN_XOR: r = {cin, a ^ b};
      FN_LOAD: r = {cin, b};
      FN_INC: r = {cin, a + 8'h01};
      FN_DEC: r = {cin, a - 8'h01};
      FN_RR: r = {a[0], a[0], a[DW-1:1]};
      FN_RL: r = {a[DW-1], a[DW-2:0], a[DW-1]};
      default: r = {cin, a};
    endcase
    return r;
  endfunction

  icp_dec_t dec;
  logic [7:0] ea;
  logic [DW-1:0] mem_rd;
  logic bnd;
  logic stall;
  logic commit;
  logic skip_taken;
  logic pcl_wr;
  logic redirect;
  logic [PC_W-1:0] target;
  logic [IW-1:0] word_in;
  logic avail;
  logic [DW:0] alu_res;

  assign dec = decode(exec_ir_q);
  // address 0 reaches memory through the pointer
  assign ea = (dec.arg == SFR_IND) ? mp_q : dec.arg;
  assign bnd = step_q && (phase_q == PH_T4);
  assign stall = exec_valid_q && dec.ext && !ext_wait_q;
  assign commit = bnd && exec_valid_q && !stall;
  assign skip_taken = dec.skip && ((opnd_q == 8'h00) ^ dec.skip_nz);
  assign pcl_wr = dec.mov_wr && (ea == SFR_PC_LOW);
  assign redirect = exec_valid_q && (dec.jmp || dec.call || dec.ret || skip_taken || pcl_wr);
  assign word_in = fetch_pend_q ? pm_data : fetch_q;
  assign avail = fetch_pend_q || held_q;

  always_comb begin
    if (dec.ret) begin
      target = stack_q[sp_q - 3'h1];
    end else if (pcl_wr) begin
      target = {exec_pc_q[PC_W-1:PAGE_LSB], acc_q};
    end else if (skip_taken) begin
      target = pc_q;
    end else begin
      target = dec.target;
    end
  end

  always_comb begin
    unique case (ea)
      SFR_IND: mem_rd = 8'h00;
      SFR_MP: mem_rd = mp_q;
      SFR_ACC: mem_rd = acc_q;
      SFR_PC_LOW: mem_rd = exec_pc_q[DW-1:0];
      SFR_STATUS: mem_rd = {6'h00, status_q};
      default: mem_rd = dmem[ea];
    endcase
  end

  always_comb begin
    if (dec.alu_lit) begin
      alu_res = alu(dec.fn, acc_q, dec.arg, status_q[ST_C]);
    end else begin
      alu_res = alu(dec.fn, acc_q, opnd_q, status_q[ST_C]);
    end
  end

  // ****************************************
  // fetch sequencing
  // ****************************************
  // the boundary edge ends T4 and opens T1 of the next cycle
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pc_q <= RESET_VEC;
      pm_req_q <= '0;
      fetch_pend_q <= 1'b0;
      held_q <= 1'b0;
      fetch_q <= 16'h0000;
      exec_ir_q <= 16'h0000;
      exec_pc_q <= RESET_VEC;
      exec_valid_q <= 1'b0;
      ext_wait_q <= 1'b0;
      dummy_q <= 1'b1;
    end else if (bnd && stall) begin
      // second cycle of an extended op: park the prefetched word
      ext_wait_q <= 1'b1;
      fetch_q <= word_in;
      held_q <= avail;
      fetch_pend_q <= 1'b0;
      pm_req_q.rd <= 1'b0;
    end else if (bnd) begin
      ext_wait_q <= 1'b0;
      held_q <= 1'b0;
      fetch_pend_q <= 1'b1;
      pm_req_q.rd <= 1'b1;
      if (redirect) begin
        // prefetched word is dropped; next cycle only fetches
        exec_valid_q <= 1'b0;
        dummy_q <= 1'b1;
        pm_req_q.addr <= target;
        pc_q <= target + 13'h0001;
      end else begin
        exec_ir_q <= word_in;
        exec_pc_q <= pm_req_q.addr;
        exec_valid_q <= avail;
        dummy_q <= !avail;
        pm_req_q.addr <= pc_q;
        pc_q <= pc_q + 13'h0001;
      end
    end else begin
      pm_req_q.rd <= 1'b0;
    end
  end

  // ****************************************
  // execute: operand read, then commit
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      opnd_q <= 8'h00;
    end else if (step_q && (phase_q == PH_T2)) begin
      opnd_q <= mem_rd;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      acc_q <= 8'h00;
      status_q <= 2'h0;
      mp_q <= 8'h00;
    end else if (commit) begin
      if (dec.alu_lit || dec.alu_mem || dec.acc_only) begin
        acc_q <= alu_res[DW-1:0];
        status_q[ST_C] <= alu_res[DW];
        status_q[ST_Z] <= (alu_res[DW-1:0] == 8'h00);
      end else if (dec.mov_rd) begin
        acc_q <= opnd_q;
      end else if (dec.mov_wr && (ea == SFR_MP)) begin
        mp_q <= acc_q;
      end else if (dec.mov_wr && (ea == SFR_STATUS)) begin
        status_q <= acc_q[1:0];
      end
    end
  end

  // general data memory, no reset: contents are undefined at power up
  always_ff @(posedge core_clk) begin
    if (commit && dec.mov_wr && (ea > SFR_STATUS)) begin
      dmem[ea] <= acc_q;
    end
  end

  // eight-level return stack; an overflow wraps onto the oldest entry
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sp_q <= 3'h0;
    end else if (commit && dec.call) begin
      stack_q[sp_q] <= exec_pc_q + 13'h0001;
      sp_q <= sp_q + 3'h1;
    end else if (commit && dec.ret) begin
      sp_q <= sp_q - 3'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      retire_q <= 1'b0;
    end else begin
      retire_q <= commit;
    end
  end

  assign pm_req = pm_req_q;
  assign phase = phase_q;
  assign instr_retire = retire_q;
  assign dummy_cycle = dummy_q;
  assign acc_out = acc_q;
endmodule

// ===== testbench/icp_core_chk.sv
// port assertions for the instruction cycle core
`timescale 1ns/10ps
module icp_core_chk import icp_pkg::*; #(
  parameter int DMEM_DEPTH = 256
) (
  input wire logic core_clk, // clock
  input wire logic sys_rst, // reset
  input wire logic [1:0] clk_src_sel, // source
  input wire icp_pm_req_t pm_req, // fetch
  input wire logic [IW-1:0] pm_data, // word
  input wire icp_phase_t phase, // phase
  input wire logic instr_retire, // retire
  input wire logic dummy_cycle, // dummy
  input wire logic [DW-1:0] acc_out // acc
);
  // ****
  // helpers
  // ****
  logic seen_q;
  logic [PC_W-1:0] last_q;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      seen_q <= 1'b0;
    end else if (pm_req.rd) begin
      seen_q <= 1'b1;
    end
  end
  always_ff @(posedge core_clk) begin
    if (pm_req.rd) begin
      last_q <= pm_req.addr;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  sequence s_no_fetch3;
    (!pm_req.rd) [*3];
  endsequence
  sequence s_no_retire3;
    (!instr_retire) [*3];
  endsequence
  // ****
  // properties
  // ****
  AST_PHASE_ORDER: assert property (
    phase != $past(phase) |-> phase == 2'($past(phase) + 2'h1))
    else $error("phase skipped a step");
  AST_FETCH_IN_T1: assert property (
    pm_req.rd |-> phase == PH_T1)
    else $error("fetch outside first phase");
  AST_FETCH_SPACING: assert property (
    pm_req.rd |=> s_no_fetch3)
    else $error("fetches closer than one cycle");
  AST_ADDR_HOLD: assert property (
    !pm_req.rd |-> $stable(pm_req.addr))
    else $error("fetch address moved between fetches");
  AST_RESET_VEC: assert property (
    pm_req.rd && !seen_q |-> pm_req.addr == RESET_VEC)
    else $error("first fetch not at reset vector");
  AST_NO_EARLY_RETIRE: assert property (
    !seen_q |-> !instr_retire)
    else $error("retire before first fetch");
  AST_RETIRE_SPACING: assert property (
    instr_retire |=> s_no_retire3)
    else $error("two retires in one cycle");
  AST_DUMMY_ALIGN: assert property (
    $rose(dummy_cycle) || $fell(dummy_cycle) |-> phase == PH_T1)
    else $error("dummy flag not on a cycle boundary");
  AST_REDIRECT_DUMMY: assert property (
    pm_req.rd && seen_q && pm_req.addr != last_q + 13'h0001 |-> ##[0:1] dummy_cycle)
    else $error("redirect without a dummy cycle");
  AST_ACC_AT_COMMIT: assert property (
    $changed(acc_out) |-> phase == PH_T1)
    else $error("accumulator changed off a boundary");
endmodule

bind icp_core icp_core_chk #(.DMEM_DEPTH(DMEM_DEPTH)) i_icp_core_chk (
  .core_clk(core_clk),
  .sys_rst(sys_rst),
  .clk_src_sel(clk_src_sel),
  .pm_req(pm_req),
  .pm_data(pm_data),
  .phase(phase),
  .instr_retire(instr_retire),
  .dummy_cycle(dummy_cycle),
  .acc_out(acc_out)
);

// ===== testbench/icp_pmem_model.sv
// behavioural program memory answering fetches
`timescale 1ns/10ps
module icp_pmem_model import icp_pkg::*; (
  input wire logic core_clk, // clock
  input wire logic slow, // answer late
  input wire icp_pm_req_t pm_req, // fetch
  output logic [IW-1:0] pm_data // word
);
  logic [IW-1:0] mem [0:255];
  logic [IW-1:0] word_q;
  logic [1:0] wait_q = 2'h0;
  always_ff @(posedge core_clk) begin
    if (pm_req.rd) begin
      word_q <= mem[pm_req.addr[7:0]];
      wait_q <= slow ? 2'h2 : 2'h0;
    end else if (wait_q != 2'h0) begin
      wait_q <= wait_q - 2'h1;
    end
  end
  // late answers show garbage first so a core sampling early is caught
  assign pm_data = (wait_q == 2'h0) ? word_q : ~word_q;
endmodule

// ===== testbench/instruction_cycle_pipeline_tb.sv
// self-checking bench for the instruction cycle core
`timescale 1ns/10ps
module instruction_cycle_pipeline_tb import icp_pkg::*;;
  logic core_clk;
  logic sys_rst;
  logic [1:0] clk_src_sel;
  logic slow_mem;
  icp_pm_req_t pm_req;
  logic [IW-1:0] pm_data;
  icp_phase_t phase;
  logic instr_retire;
  logic dummy_cycle;
  logic [DW-1:0] acc_out;
  int num_errors;
  int tests_run;
  int seed = 40;
  logic [PC_W-1:0] exp_addr [0:10];
  logic exp_dummy [0:10];

  icp_core #(.DMEM_DEPTH(256)) i_icp_core (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .clk_src_sel(clk_src_sel),
    .pm_req(pm_req),
    .pm_data(pm_data),
    .phase(phase),
    .instr_retire(instr_retire),
    .dummy_cycle(dummy_cycle),
    .acc_out(acc_out)
  );
  icp_pmem_model i_icp_pmem_model (
    .core_clk(core_clk),
    .slow(slow_mem),
    .pm_req(pm_req),
    .pm_data(pm_data)
  );

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  function automatic logic [IW-1:0] enc(input logic [2:0] op, input logic [3:0] fn,
                                        input logic [7:0] arg);
    return {op, 1'b0, fn, arg};
  endfunction

  function automatic int div_of(input logic [1:0] src);
    case (src)
      SRC_HS_XTAL: return int'(DIV_HS_XTAL);
      SRC_LS_XTAL: return int'(DIV_LS_XTAL);
      SRC_HS_IRC: return int'(DIV_HS_IRC);
      default: return int'(DIV_LS_IRC);
    endcase
  endfunction

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check_val(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_flag(input string what, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask

  // bounded wait for the next fetch strobe, then sample the dummy flag
  task automatic wait_fetch(output logic [PC_W-1:0] a, output int gap, output logic dum);
    gap = 0;
    while (pm_req.rd !== 1'b1) begin
      tick(1);
      gap++;
      if (gap > 400) begin
        num_errors++;
        $display("FAIL fetch strobe expected 1 seen 0");
        give_verdict();
      end
    end
    a = pm_req.addr;
    tick(1);
    dum = dummy_cycle;
  endtask

  initial begin
    logic [7:0] r, s, t, u;
    logic [PC_W-1:0] a;
    logic dum;
    int gap, d;
    num_errors = 0;
    tests_run = 0;
    sys_rst = 1'b1;
    clk_src_sel = 2'h0;
    slow_mem = 1'b0;
    exp_addr = '{13'h0, 13'h1, 13'h2, 13'h3, 13'h10, 13'h11, 13'h12, 13'h13, 13'h14,
                 13'h15, 13'h16};
    exp_dummy = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
    tick(1);
    for (int src = 0; src < 4; src++) begin
      r = 8'($random(seed));
      s = 8'($random(seed));
      t = 8'($random(seed));
      u = 8'($random(seed));
      // carry wraps the sum to zero on the first pass
      if (src == 0) begin
        r = 8'hff;
        s = 8'h01;
      end
      d = div_of(2'(src));
      i_icp_pmem_model.mem[0] = enc(OP_ALU_LIT, FN_LOAD, r);
      i_icp_pmem_model.mem[1] = enc(OP_ALU_LIT, FN_ADD, s);
      i_icp_pmem_model.mem[2] = {OP_JMP, 13'h0010};
      i_icp_pmem_model.mem[3] = enc(OP_ALU_LIT, FN_LOAD, 8'hee);
      i_icp_pmem_model.mem[16] = enc(OP_ALU_LIT, FN_XOR, 8'(r + s));
      i_icp_pmem_model.mem[17] = enc(OP_SKIP, 4'h0, SFR_ACC);
      i_icp_pmem_model.mem[18] = enc(OP_ALU_LIT, FN_LOAD, 8'hff);
      i_icp_pmem_model.mem[19] = enc(OP_EXT, FN_ADD, SFR_ACC);
      i_icp_pmem_model.mem[20] = enc(OP_ALU_LIT, FN_ADD, t);
      i_icp_pmem_model.mem[21] = enc(OP_ALU_LIT, FN_XOR, u);
      // call out, save acc, page jump by pc low write, read back through pointer, return
      i_icp_pmem_model.mem[22] = {OP_CALL, 13'h0030};
      i_icp_pmem_model.mem[23] = enc(OP_MISC, FN_INC, 8'h00);
      i_icp_pmem_model.mem[24] = {OP_JMP, 13'h0018};
      i_icp_pmem_model.mem[48] = enc(OP_MOV, 4'h0, 8'h40);
      i_icp_pmem_model.mem[49] = enc(OP_ALU_LIT, FN_LOAD, 8'h40);
      i_icp_pmem_model.mem[50] = enc(OP_MOV, 4'h0, SFR_MP);
      i_icp_pmem_model.mem[51] = enc(OP_ALU_LIT, FN_LOAD, 8'h36);
      i_icp_pmem_model.mem[52] = enc(OP_MOV, 4'h0, SFR_PC_LOW);
      i_icp_pmem_model.mem[53] = enc(OP_ALU_LIT, FN_LOAD, 8'hee);
      i_icp_pmem_model.mem[54] = enc(OP_MOV, 4'h1, SFR_IND);
      i_icp_pmem_model.mem[55] = enc(OP_MISC, MISC_RET, 8'h00);
      sys_rst = 1'b1;
      clk_src_sel = 2'(src);
      slow_mem = src[0];
      tick(6);
      check_val("reset phase", 16'(PH_T1), 16'(phase));
      check_flag("reset fetch", 1'b0, pm_req.rd);
      check_flag("reset dummy", 1'b1, dummy_cycle);
      check_flag("reset retire", 1'b0, instr_retire);
      check_val("reset acc", 16'h0000, 16'(acc_out));
      sys_rst = 1'b0;
      for (int k = 0; k < 11; k++) begin
        wait_fetch(a, gap, dum);
        check_val("fetch address", 16'(exp_addr[k]), 16'(a));
        check_flag("dummy cycle", exp_dummy[k], dum);
        if (k > 0) begin
          check_val("fetch spacing", 16'((k == 9 ? 8 : 4) * d), 16'(gap + 1));
        end
      end
      // sixteen instruction cycles cover the call, the dummies after the call, the pc low write and the return, and the return itself
      tick(64 * d);
      check_val("accumulator", 16'(8'((t ^ u) + 8'h01)), 16'(acc_out));
      $display("test source %0d done", src);
    end
    give_verdict();
  end
endmodule
